// ===== rtl/dcf_pkg.sv
// shared constants, types and helpers for the clocked fifo bank with flag logic
package dcf_pkg;

  // data path and depth range
  localparam int DCF_DATA_W = 18;
  localparam int DCF_OFFS_W = 12;
  localparam int DCF_DEPTH_MIN = 256;
  localparam int DCF_DEPTH_MAX = 4096;
  localparam int DCF_DEPTH_DEF = 256;

  // default offsets per depth class (reset values of both offset registers)
  localparam logic [11:0] DCF_OFFS_D256 = 12'h01f;
  localparam logic [11:0] DCF_OFFS_D512 = 12'h03f;
  localparam logic [11:0] DCF_OFFS_BIG = 12'h07f;

  // first word reaches the outputs on this read clock edge after the write
  localparam int DCF_FALL_THROUGH_MODE_LAT = 3;

  // threshold adders: standard mode, then fall-through mode
  localparam int DCF_STD_AE_ADD = 1;
  localparam int DCF_FALL_THROUGH_MODE_AE_ADD = 2;
  localparam int DCF_STD_HF_ADD = 1;
  localparam int DCF_FALL_THROUGH_MODE_HF_ADD = 2;
  localparam int DCF_FALL_THROUGH_MODE_CAP_ADD = 1;

  // strap pattern {initial_load_select, read_expansion, write_expansion}
  localparam logic [2:0] DCF_STRAP_FALL_THROUGH_MODE = 3'h1;

  typedef enum logic {
    DCF_MODE_STD = 1'b0,
    DCF_MODE_FALL_THROUGH_MODE = 1'b1
  } dcf_mode_type;

  // offset sequence state, used for loading and for readback
  typedef enum logic {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL = 1'b1
  } dcf_sel_type;

  localparam dcf_sel_type DCF_SEL_RESET = DCF_SEL_EMPTY;

  typedef struct packed {
    logic initial_load_select;
    logic read_expansion;
    logic write_expansion;
  } dcf_strap_type;

  typedef struct packed {
    logic empty_or_n;
    logic full_ir_n;
    logic half_full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcf_flags_type;

  typedef struct packed {
    logic [DCF_OFFS_W-1:0] empty_offs;
    logic [DCF_OFFS_W-1:0] full_offs;
  } dcf_offs_type;

  // default offset for a given depth
  function automatic logic [DCF_OFFS_W-1:0] dcf_default_offset(input int depth);
    if (depth <= 256) begin
      return DCF_OFFS_D256;
    end else if (depth <= 512) begin
      return DCF_OFFS_D512;
    end
    return DCF_OFFS_BIG;
  endfunction

endpackage

// ===== rtl/dcf_ram.sv
// storage array with registered read port and a load path for readback values
`timescale 1ns/1ps
module dcf_ram #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  input wire logic load_en_in,
  input wire logic [WIDTH-1:0] load_data_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("dcf_ram: DEPTH must equal 2**AW");
  end

  // array write, no reset so it maps to block memory
  always_ff @(posedge clk_in) begin
    if (clk_en_in && wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // load path wins over a memory read; only one is asked for at a time
  always_comb begin
    next_rd_data = rd_data_out;
    if (load_en_in) begin
      next_rd_data = load_data_in;
    end else if (rd_en_in) begin
      next_rd_data = mem[rd_addr_in];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (clk_en_in) begin
      rd_data_out <= next_rd_data;
    end
  end

endmodule // dcf_ram

// ===== rtl/dcf_flag_calc.sv
// threshold compare that turns a word count into the five flag levels
`timescale 1ns/1ps
module dcf_flag_calc import dcf_pkg::*; #(
  parameter int DEPTH = 256,
  parameter int CW = 9
) (
  input wire logic [CW-1:0] count_in,
  input wire logic out_valid_in,
  input wire dcf_mode_type mode_in,
  input wire dcf_offs_type offs_in,
  output dcf_flags_type flags_out
);

  // compare in 14 bits so offset plus adder never wraps
  localparam int TW = 14;
  localparam logic [TW-1:0] DEPTH_T = TW'(DEPTH);
  localparam logic [TW-1:0] HALF_T = TW'(DEPTH / 2);

  logic [TW-1:0] cnt;
  logic [TW-1:0] n_off;
  logic [TW-1:0] m_off;
  logic fall_through_mode;

  assign cnt = TW'(count_in);
  assign n_off = TW'(offs_in.empty_offs);
  assign m_off = TW'(offs_in.full_offs);
  assign fall_through_mode = (mode_in == DCF_MODE_FALL_THROUGH_MODE);

  // both modes share one set of pins; polarity of the boundary flags flips
  always_comb begin
    if (fall_through_mode) begin
      flags_out.empty_or_n = ~out_valid_in; // R13
      flags_out.full_ir_n = (cnt >= DEPTH_T + TW'(DCF_FALL_THROUGH_MODE_CAP_ADD)); // R17
      flags_out.half_full_n = ~(cnt >= HALF_T + TW'(DCF_FALL_THROUGH_MODE_HF_ADD)); // R15
      flags_out.almost_empty_n = (cnt >= n_off + TW'(DCF_FALL_THROUGH_MODE_AE_ADD)); // R14
      flags_out.almost_full_n = ~(cnt + m_off >= DEPTH_T + TW'(DCF_FALL_THROUGH_MODE_CAP_ADD)); // R16
    end else begin
      flags_out.empty_or_n = (cnt != '0); // R5
      flags_out.full_ir_n = ~(cnt >= DEPTH_T); // R10
      flags_out.half_full_n = ~(cnt >= HALF_T + TW'(DCF_STD_HF_ADD)); // R8
      flags_out.almost_empty_n = (cnt >= n_off + TW'(DCF_STD_AE_ADD)); // R6
      flags_out.almost_full_n = ~(cnt + m_off >= DEPTH_T); // R9
    end
  end

endmodule // dcf_flag_calc

// ===== rtl/dcf_bank.sv
// one fifo bank: pointers, fall-through prefetch, offset registers and flags
`timescale 1ns/1ps
// Contract
// [R1] Timing mode is taken from the three strap pins while reset is held.
// [R2] Standard mode: stored word reaches outputs only on a read edge.
// [R3] Fall-through mode: first word shows on outputs three edges after its write.
// [R4] A word is captured on each edge with write enable low.
// [R5] Standard mode: empty flag rises after the first write into empty bank.
// [R6] Standard mode: almost-empty high at n+1 words or more, low at n.
// [R7] Default empty offset is 31, 63 or 127 by depth class.
// [R8] Standard mode: half-full low once half depth plus one words are stored.
// [R9] Standard mode: almost-full low at depth minus m words.
// [R10] Standard mode: full flag low at depth words; writes then inhibited.
// [R11] First read from full clears full indication; later reads release partial flags.
// [R12] After last word read, empty is shown and read enable ignored.
// [R13] Fall-through mode: output-ready low once valid data sits on outputs.
// [R14] Fall-through mode: almost-empty high at n+2 words, low at n+1 or fewer.
// [R15] Fall-through mode: half-full low at half depth plus two words.
// [R16] Fall-through mode: almost-full low at depth plus one minus m words.
// [R17] Fall-through mode: input-ready high at depth plus one words, writes inhibited.
// [R18] Load strobe and write enable low write empty, full, empty offsets in turn.
// [R19] Raising load strobe resumes normal use; the sequence position is kept.
// [R20] Load strobe and read enable low present empty then full offset on outputs.
// [R21] Offset readback works in standard mode only.
// [R22] Straps 0,0,1 pick fall-through mode; other listed patterns pick standard.
// [R23] Default offsets are 63 words for depth 512.
// [R24] Reset empties bank, restores offsets, rewinds sequence, drives empty-state flags.
module dcf_bank import dcf_pkg::*; #(
  parameter int DEPTH = DCF_DEPTH_DEF,
  parameter int DATA_W = DCF_DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic initial_load_select_in,
  input wire logic read_expansion_in,
  input wire logic write_expansion_in,
  input wire logic write_enable_n_in,
  input wire logic read_enable_n_in,
  input wire logic offset_load_strobe_n_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic empty_flag_n_out,
  output logic full_flag_n_out,
  output logic half_full_n_out,
  output logic almost_empty_n_out,
  output logic almost_full_n_out,
  output logic fall_through_mode_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int VIS = DCF_FALL_THROUGH_MODE_LAT - 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] CAP_STD = PW'(DEPTH);
  localparam logic [PW-1:0] CAP_FALL_THROUGH_MODE = PW'(DEPTH + DCF_FALL_THROUGH_MODE_CAP_ADD);
  localparam logic [DCF_OFFS_W-1:0] OFFS_DEF = dcf_default_offset(DEPTH); // R7 R23

  // refuse depths the pointer logic cannot serve
  if (DEPTH < DCF_DEPTH_MIN || DEPTH > DCF_DEPTH_MAX || DEPTH != (1 << AW)) begin : g_bad_depth
    $error("dcf_bank: DEPTH must be a power of two from 256 to 4096");
  end
  if (DATA_W < DCF_OFFS_W) begin : g_bad_width
    $error("dcf_bank: DATA_W must hold a full offset");
  end

  // registered state
  dcf_mode_type mode;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_vis [VIS];
  logic out_valid;
  dcf_offs_type offs;
  dcf_sel_type load_sel;
  dcf_sel_type rb_sel;
  dcf_flags_type flags;

  // next values
  dcf_mode_type next_mode;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW-1:0] next_wr_vis [VIS];
  logic next_out_valid;
  dcf_offs_type next_offs;
  dcf_sel_type next_load_sel;
  dcf_sel_type next_rb_sel;
  dcf_flags_type next_flags;

  // decoded controls
  dcf_strap_type strap;
  logic fall_through_mode;
  logic [PW-1:0] mem_level;
  logic [PW-1:0] avail_level;
  logic [PW-1:0] word_count;
  logic [PW-1:0] next_count;
  logic [PW-1:0] calc_count;
  logic calc_valid;
  dcf_mode_type calc_mode;
  dcf_offs_type calc_offs;
  logic wr_acc;
  logic std_pop;
  logic fall_through_mode_take;
  logic prefetch;
  logic rd_en;
  logic offs_wr;
  logic rb_en;
  logic [DATA_W-1:0] rb_data;
  logic [DATA_W-1:0] ram_q;

  assign strap = '{initial_load_select: initial_load_select_in,
                   read_expansion: read_expansion_in,
                   write_expansion: write_expansion_in};
  assign fall_through_mode = (mode == DCF_MODE_FALL_THROUGH_MODE);

  // fill levels; in fall-through the output register counts as one more word
  assign mem_level = wr_ptr - rd_ptr;
  assign avail_level = wr_vis[VIS-1] - rd_ptr;
  assign word_count = mem_level + PW'(fall_through_mode & out_valid);

  // write side: refused when full, and when the array itself is full while the
  // output register is still being refilled (only during the fall-through delay)
  assign wr_acc = clk_en_in && !write_enable_n_in && offset_load_strobe_n_in
                  && (word_count < (fall_through_mode ? CAP_FALL_THROUGH_MODE : CAP_STD))
                  && (mem_level != DEPTH_P); // R4 R10 R17

  // read side: standard pops the array straight into the output register
  assign std_pop = !fall_through_mode && clk_en_in && !read_enable_n_in && offset_load_strobe_n_in
                   && (mem_level != '0); // R2 R12
  // fall-through read consumes the word already shown
  assign fall_through_mode_take = fall_through_mode && clk_en_in && !read_enable_n_in && offset_load_strobe_n_in
                     && out_valid; // R12
  // refill only from words whose write has ripped through the visibility delay
  assign prefetch = fall_through_mode && clk_en_in && (avail_level != '0)
                    && (!out_valid || fall_through_mode_take); // R3
  assign rd_en = std_pop || prefetch;

  // offset port: loads on the write side, readback on the read side
  assign offs_wr = clk_en_in && !offset_load_strobe_n_in && !write_enable_n_in; // R18
  assign rb_en = !fall_through_mode && clk_en_in && !offset_load_strobe_n_in && !read_enable_n_in; // R20 R21
  assign rb_data = {{(DATA_W - DCF_OFFS_W){1'b0}},
                    (rb_sel == DCF_SEL_EMPTY) ? offs.empty_offs : offs.full_offs};

  // mode latch: straps only matter while reset is held
  always_comb begin
    next_mode = mode;
    if (rst_in) begin
      next_mode = (strap == DCF_STRAP_FALL_THROUGH_MODE) ? DCF_MODE_FALL_THROUGH_MODE : DCF_MODE_STD; // R1 R22
    end
  end

  // pointers and the fall-through holding stage
  always_comb begin
    next_wr_ptr = wr_ptr + PW'(wr_acc); // R4
    next_rd_ptr = rd_ptr + PW'(rd_en);
    next_wr_vis[0] = wr_ptr; // R3
    for (int i = 1; i < VIS; i++) begin
      next_wr_vis[i] = wr_vis[i-1];
    end
    next_out_valid = fall_through_mode && (prefetch || (out_valid && !fall_through_mode_take)); // R3 R13
  end

  // offset registers and their two sequence pointers; a stray strobe with
  // neither enable low leaves both pointers where they were
  always_comb begin
    next_offs = offs;
    next_load_sel = load_sel;
    next_rb_sel = rb_sel;
    if (offs_wr) begin
      case (load_sel)
        DCF_SEL_EMPTY: begin
          next_offs.empty_offs = data_in[DCF_OFFS_W-1:0]; // R18
          next_load_sel = DCF_SEL_FULL;
        end
        DCF_SEL_FULL: begin
          next_offs.full_offs = data_in[DCF_OFFS_W-1:0]; // R18
          next_load_sel = DCF_SEL_EMPTY; // R19
        end
        default: begin
          next_load_sel = DCF_SEL_EMPTY;
        end
      endcase
    end
    if (rb_en) begin
      case (rb_sel)
        DCF_SEL_EMPTY: next_rb_sel = DCF_SEL_FULL; // R20
        DCF_SEL_FULL: next_rb_sel = DCF_SEL_EMPTY;
        default: next_rb_sel = DCF_SEL_EMPTY;
      endcase
    end
  end

  // flag inputs: during reset the calculator sees an empty bank in the new mode
  always_comb begin
    next_count = (next_wr_ptr - next_rd_ptr) + PW'(fall_through_mode & next_out_valid);
    calc_count = next_count;
    calc_valid = next_out_valid;
    calc_mode = mode;
    calc_offs = next_offs;
    if (rst_in) begin
      calc_count = '0; // R24
      calc_valid = 1'b0;
      calc_mode = next_mode;
      calc_offs = '{empty_offs: OFFS_DEF, full_offs: OFFS_DEF};
    end
  end

  dcf_flag_calc #(
    .DEPTH(DEPTH),
    .CW(PW)
  ) u_flag_calc (
    .count_in(calc_count),
    .out_valid_in(calc_valid),
    .mode_in(calc_mode),
    .offs_in(calc_offs),
    .flags_out(next_flags)
  );

  dcf_ram #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_ram (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(wr_acc),
    .wr_addr_in(wr_ptr[AW-1:0]),
    .wr_data_in(data_in),
    .rd_en_in(rd_en),
    .rd_addr_in(rd_ptr[AW-1:0]),
    .load_en_in(rb_en),
    .load_data_in(rb_data),
    .rd_data_out(ram_q)
  );

  // state registers; reset overrides the clock enable so straps always latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode <= next_mode; // R1
      wr_ptr <= '0; // R24
      rd_ptr <= '0;
      for (int i = 0; i < VIS; i++) begin
        wr_vis[i] <= '0;
      end
      out_valid <= 1'b0;
      offs <= '{empty_offs: OFFS_DEF, full_offs: OFFS_DEF}; // R7 R23 R24
      load_sel <= DCF_SEL_RESET; // R24
      rb_sel <= DCF_SEL_RESET;
      flags <= next_flags; // R24
    end else if (clk_en_in) begin
      mode <= next_mode;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      wr_vis <= next_wr_vis;
      out_valid <= next_out_valid;
      offs <= next_offs;
      load_sel <= next_load_sel;
      rb_sel <= next_rb_sel;
      flags <= next_flags; // R11 R12
    end
  end

  // outputs all come straight from flops
  assign data_out = ram_q;
  assign empty_flag_n_out = flags.empty_or_n;
  assign full_flag_n_out = flags.full_ir_n;
  assign half_full_n_out = flags.half_full_n;
  assign almost_empty_n_out = flags.almost_empty_n;
  assign almost_full_n_out = flags.almost_full_n;
  assign fall_through_mode_out = fall_through_mode;

  // checks
  AST_STD_HOLD_Q: assert property ( // R2
    @(posedge clk_in) disable iff (rst_in)
    (!fall_through_mode && !(clk_en_in && !read_enable_n_in)) |=> $stable(data_out))
    else $error("data outputs moved without a read in standard mode");

  AST_FALL_THROUGH_MODE_FIRST_LATE: assert property ( // R3
    @(posedge clk_in) disable iff (rst_in)
    (fall_through_mode && wr_acc && word_count == '0) ##1 clk_en_in[*3] |=> !empty_flag_n_out)
    else $error("first fall-through word not ready after three edges");

  AST_FALL_THROUGH_MODE_FIRST_NOT_EARLY: assert property ( // R3
    @(posedge clk_in) disable iff (rst_in)
    (fall_through_mode && wr_acc && word_count == '0) |=> empty_flag_n_out[*3])
    else $error("first fall-through word appeared too early");

  AST_WRITE_COUNTS: assert property ( // R4
    @(posedge clk_in) disable iff (rst_in)
    (wr_acc && !rd_en && !fall_through_mode) |=> word_count == $past(word_count) + PW'(1))
    else $error("accepted write did not add one word");

  AST_STD_EF_RISE: assert property ( // R5
    @(posedge clk_in) disable iff (rst_in)
    (!fall_through_mode && wr_acc) |=> empty_flag_n_out)
    else $error("empty flag low after a standard-mode write");

  AST_STD_AE_LEVEL: assert property ( // R6
    @(posedge clk_in) disable iff (rst_in)
    !fall_through_mode |-> almost_empty_n_out == (14'(word_count) >= 14'(offs.empty_offs) + 14'(DCF_STD_AE_ADD)))
    else $error("standard almost-empty level wrong");

  AST_STD_HF_LEVEL: assert property ( // R8
    @(posedge clk_in) disable iff (rst_in)
    !fall_through_mode |-> half_full_n_out == (word_count <= PW'(DEPTH / 2)))
    else $error("standard half-full level wrong");

  AST_FULL_BLOCKS: assert property ( // R10
    @(posedge clk_in) disable iff (rst_in)
    (!fall_through_mode && !full_flag_n_out) |-> !wr_acc ##1 (word_count <= $past(word_count)))
    else $error("write accepted while full");

  AST_EMPTY_IGNORES_READ: assert property ( // R12
    @(posedge clk_in) disable iff (rst_in)
    (!fall_through_mode && word_count == '0) |=> rd_ptr == $past(rd_ptr))
    else $error("read pointer moved on an empty bank");

  AST_FALL_THROUGH_MODE_IR_LEVEL: assert property ( // R17
    @(posedge clk_in) disable iff (rst_in)
    fall_through_mode |-> full_flag_n_out == (word_count == CAP_FALL_THROUGH_MODE))
    else $error("input-ready level wrong in fall-through mode");

  AST_OFFS_SEQ_STEP: assert property ( // R18
    @(posedge clk_in) disable iff (rst_in)
    offs_wr |=> load_sel != $past(load_sel))
    else $error("offset load sequence did not advance");

  AST_NO_FALL_THROUGH_MODE_READBACK: assert property ( // R21
    @(posedge clk_in) disable iff (rst_in)
    (fall_through_mode && !offset_load_strobe_n_in) |=> rb_sel == $past(rb_sel))
    else $error("offset readback sequence moved in fall-through mode");

  // readback opens with the empty offset, then hands over to the full one
  AST_RB_EMPTY_FIRST: assert property ( // R20
    @(posedge clk_in) disable iff (rst_in)
    (rb_en && rb_sel == DCF_SEL_EMPTY)
    |=> (data_out[DCF_OFFS_W-1:0] == $past(offs.empty_offs)) && (rb_sel == DCF_SEL_FULL))
    else $error("offset readback did not show the empty offset first");

  // with the strobe high the load sequence must stay where it was left
  AST_LOAD_SEQ_KEPT: assert property ( // R19
    @(posedge clk_in) disable iff (rst_in)
    offset_load_strobe_n_in |=> load_sel == $past(load_sel))
    else $error("offset load sequence moved while the strobe was high");

  // the output register adds one word to the almost-full threshold
  AST_FALL_THROUGH_MODE_AF_LEVEL: assert property ( // R16
    @(posedge clk_in) disable iff (rst_in)
    fall_through_mode |-> almost_full_n_out == (14'(word_count) + 14'(offs.full_offs) < 14'(DEPTH) + 14'(DCF_FALL_THROUGH_MODE_CAP_ADD)))
    else $error("fall-through almost-full level wrong");

endmodule // dcf_bank

// ===== testbench/dcf_host_model.sv
// partner model: writer and reader logic driving the bank's enable and data pins
`timescale 1ns/1ps
module dcf_host_model import dcf_pkg::*; (
  input wire logic clk_in,
  output logic write_enable_n_out,
  output logic read_enable_n_out,
  output logic offset_load_strobe_n_out,
  output logic [DCF_DATA_W-1:0] data_out
);
  // idle levels from time zero so the bank never sees an unknown enable
  initial begin
    write_enable_n_out = 1'b1;
    read_enable_n_out = 1'b1;
    offset_load_strobe_n_out = 1'b1;
    data_out = '0;
  end

  // one request per clock: changed just after an edge, held for the whole period
  task automatic op(input logic we_n, input logic re_n, input logic ld_n, input logic [DCF_DATA_W-1:0] d);
    @(posedge clk_in);
    #1;
    write_enable_n_out = we_n;
    read_enable_n_out = re_n;
    offset_load_strobe_n_out = ld_n;
    // unused data lines toggle so a stale word can never look valid
    data_out = we_n ? ~data_out : d;
  endtask
endmodule // dcf_host_model

// ===== testbench/tb.sv
// self-checking bench for the fifo bank in standard and fall-through modes
`timescale 1ns/1ps
module tb import dcf_pkg::*;;
  localparam int D = 256;
  localparam int CYC_LIMIT = 4000;
  typedef struct packed {
    logic hd;
    logic [DCF_DATA_W-1:0] d;
    logic [5:0] f;
  } dcf_note_type;
  logic clk_in, rst_in, load_sel, rxp, wxp, we_n, re_n, ld_n;
  logic [DCF_DATA_W-1:0] din, dout, last_out;
  logic ef_n, ff_n, hf_n, ae_n, af_n, fw_out;
  logic fw, vis, sel_ld, sel_rb, ce;
  logic [15:0] lfsr;
  int err_count, tests_run, cycles, cnt, n, m, vdly;
  logic [DCF_DATA_W-1:0] ref_q[$];
  dcf_note_type exp_q[$];
  logic [2:0] std_straps [3] = '{3'h0, 3'h2, 3'h3};

  // clock enable comes from the bench so that a frozen edge can be tried
  dcf_bank #(.DEPTH(D)) uut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(ce),
    .initial_load_select_in(load_sel), .read_expansion_in(rxp), .write_expansion_in(wxp),
    .write_enable_n_in(we_n), .read_enable_n_in(re_n), .offset_load_strobe_n_in(ld_n),
    .data_in(din), .data_out(dout), .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n),
    .half_full_n_out(hf_n), .almost_empty_n_out(ae_n), .almost_full_n_out(af_n),
    .fall_through_mode_out(fw_out));
  dcf_host_model host (.clk_in(clk_in), .write_enable_n_out(we_n), .read_enable_n_out(re_n),
    .offset_load_strobe_n_out(ld_n), .data_out(din));

  // 50 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // flag levels {mode, empty/ready, full/ready, half, almost empty, almost full} from the word count
  function automatic logic [5:0] exp_flags();
    if (!fw) return {1'b0, cnt > 0, cnt < D, cnt < D / 2 + 1, cnt >= n + 1, cnt < D - m};
    return {1'b1, !vis, cnt >= D + 1, cnt < D / 2 + 2, cnt >= n + 2, cnt < D + 1 - m};
  endfunction

  // note what the next edge must show; fall-through words become visible three edges late
  task automatic push();
    dcf_note_type nt;
    if (fw && !vis && cnt > 0) begin
      if (vdly == 0) vis = 1'b1;
      else vdly--;
    end
    nt.hd = fw ? vis : 1'b1;
    nt.d = (fw && vis) ? ref_q[0] : last_out;
    nt.f = exp_flags();
    exp_q.push_back(nt);
  endtask

  task automatic wr();
    lfsr = lfsr_step(lfsr);
    host.op(1'b0, 1'b1, 1'b1, {lfsr[1:0], lfsr});
    if (cnt < (fw ? D + 1 : D)) begin
      if (fw && cnt == 0) vdly = 3;
      ref_q.push_back({lfsr[1:0], lfsr});
      cnt++;
    end
    push();
  endtask

  task automatic rd();
    host.op(1'b1, 1'b0, 1'b1, '0);
    if (cnt > 0 && (!fw || vis)) begin
      last_out = ref_q.pop_front();
      cnt--;
      if (cnt == 0) vis = 1'b0;
    end
    push();
  endtask

  task automatic idle();
    host.op(1'b1, 1'b1, 1'b1, '0);
    push();
  endtask

  // write and read offered with the clock enable low change nothing; standard mode only,
  // since the model's fall-through delay does not pause
  task automatic frz();
    lfsr = lfsr_step(lfsr);
    host.op(1'b0, 1'b0, 1'b1, {lfsr[1:0], lfsr});
    ce = 1'b0;
    push();
    idle();
    ce = 1'b1;
  endtask

  task automatic load_offs(input logic [11:0] v);
    host.op(1'b0, 1'b1, 1'b0, {6'h00, v});
    if (sel_ld) m = v;
    else n = v;
    sel_ld = ~sel_ld;
    push();
  endtask

  task automatic read_offs();
    host.op(1'b1, 1'b0, 1'b0, '0);
    if (!fw) begin
      last_out = {6'h00, sel_rb ? m[11:0] : n[11:0]};
      sel_rb = ~sel_rb;
    end
    push();
  endtask

  // reset for three cycles with the given straps; model state returns to defaults
  task automatic reset_dut(input logic [2:0] straps);
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    {load_sel, rxp, wxp} = straps;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    fw = (straps == 3'h1);
    cnt = 0;
    n = DCF_OFFS_D256;
    m = DCF_OFFS_D256;
    vis = 1'b0;
    vdly = 0;
    sel_ld = 1'b0;
    sel_rb = 1'b0;
    last_out = '0;
    ref_q.delete();
  endtask

  task automatic check_flags(input logic [5:0] e);
    tests_run++;
    if ({fw_out, ef_n, ff_n, hf_n, ae_n, af_n} !== e) begin
      err_count++;
      $display("FAIL %0t flags %b expected %b", $time, {fw_out, ef_n, ff_n, hf_n, ae_n, af_n}, e);
    end
  endtask

  task automatic check_data(input logic [DCF_DATA_W-1:0] e);
    tests_run++;
    if (dout !== e) begin
      err_count++;
      $display("FAIL %0t data %h expected %h", $time, dout, e);
    end
  endtask

  task automatic final_report();
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // monitor: each note belongs to the edge after it was made; outputs are read once settled
  always @(posedge clk_in) begin
    dcf_note_type nt;
    if (exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      #2;
      check_flags(nt.f);
      if (nt.hd) check_data(nt.d);
    end
  end

  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == CYC_LIMIT) begin
      err_count++;
      $display("FAIL %0t run did not finish", $time);
      final_report();
    end
  end

  initial begin
    rst_in = 1'b1;
    {load_sel, rxp, wxp} = 3'h0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    ce = 1'b1;
    lfsr = 16'h6f60;
    fw = 1'b0;
    // standard strap patterns 0, 2 and 3, each followed by a look at the reset state
    foreach (std_straps[i]) begin
      reset_dut(std_straps[i]);
      idle();
    end
    // fill past capacity, then drain past empty
    repeat (D + 1) wr();
    repeat (D + 1) rd();
    // offsets loaded with a pause in between, then read back in sequence
    load_offs(12'h009);
    idle();
    load_offs(12'h006);
    load_offs(12'h004);
    repeat (3) read_offs();
    repeat (6) wr();
    frz();
    repeat (6) rd();
    // fall-through: first word shows without a read; readback is ignored
    reset_dut(3'h1);
    idle();
    wr();
    repeat (3) idle();
    read_offs();
    repeat (D + 1) wr();
    repeat (D + 2) rd();
    idle();
    idle();
    // let the monitor compare the last note before the verdict
    @(posedge clk_in);
    #3;
    final_report();
  end
endmodule // tb
